// ---- hdl/fpo_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// ------------------------------------------------------------
module fpo_top #(
    parameter int unsigned PERIOD_W = 24
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire fpo_pkg::fpo_reg_req_t i_req,
    input wire logic i_lock,
    output logic [7:0] o_rdata,
    // Per-channel controls from tach and ramp logic
    input wire logic [2:0] i_enhanced,
    input wire logic [2:0] i_skip_initial_edges,
    input wire logic [3*PERIOD_W-1:0] i_pwm_frequency_config,
    input wire logic [23:0] i_duty,
    input wire logic [2:0] i_spinup,
    input wire logic [2:0] i_ramp_tick,
    input wire logic [2:0] i_tach_pin,
    input wire logic [2:0] i_reading_valid,
    // Outputs
    output logic [2:0] o_pwm,
    output logic [2:0] o_refresh,
    output logic [2:0] o_edge_count_en,
    output logic [2:0] o_tach_edge
);
    // ------------------------------------------------------------
    // Option registers
    // ------------------------------------------------------------
    logic [7:0] opt_q [3];
    logic [7:0] opt_d [3];
    logic [7:0] rdata_q, rdata_d;

    function automatic logic [1:0] chan_of(input logic [7:0] a);
        chan_of = 2'(a - fpo_pkg::PWM1_SAMPLING_OPTIONS_ADDR);
    endfunction

    function automatic logic hit(input logic [7:0] a);
        hit = a >= fpo_pkg::PWM1_SAMPLING_OPTIONS_ADDR && a <= fpo_pkg::PWM3_SAMPLING_OPTIONS_ADDR;
    endfunction

    always_comb
    begin
        for (int i = 0; i < 3; i++)
            opt_d[i] = opt_q[i];
        if (i_req.wr && !i_lock && hit(i_req.addr))
            opt_d[chan_of(i_req.addr)] = i_req.wdata & fpo_pkg::OPT_WRITE_MASK;
        rdata_d = rdata_q;
        if (i_req.rd)
            rdata_d = hit(i_req.addr) ? opt_q[chan_of(i_req.addr)] : 8'h00;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < 3; i++)
                opt_q[i] <= fpo_pkg::OPT_RESET;
            rdata_q <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                opt_q[i] <= opt_d[i];
            rdata_q <= rdata_d;
        end
    end
    assign o_rdata = rdata_q;

    // ------------------------------------------------------------
    // Shared dividers: 1 ms and 90 kHz ticks
    // ------------------------------------------------------------
    logic [15:0] ms_div_q, ms_div_d;
    logic [9:0] g_div_q, g_div_d;
    logic ms_tick, guard_tick;

    always_comb
    begin
        ms_tick = ms_div_q == 16'(fpo_pkg::MS_CYCLES - 1);
        guard_tick = g_div_q == 10'(fpo_pkg::GUARD_DIV - 1);
        ms_div_d = ms_tick ? 16'h0000 : ms_div_q + 16'h0001;
        g_div_d = guard_tick ? 10'h000 : g_div_q + 10'h001;
    end

    // ------------------------------------------------------------
    // Tach pin synchroniser and edge detect
    // ------------------------------------------------------------
    logic [2:0] t_s1_q, t_s2_q, t_s3_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ms_div_q <= 16'h0000;
            g_div_q <= 10'h000;
            // Tach idles high on its pull-up; resetting low would fake an edge
            t_s1_q <= 3'h7;
            t_s2_q <= 3'h7;
            t_s3_q <= 3'h7;
        end
        else
        begin
            ms_div_q <= ms_div_d;
            g_div_q <= g_div_d;
            t_s1_q <= i_tach_pin;
            t_s2_q <= t_s1_q;
            t_s3_q <= t_s2_q;
        end
    end
    assign o_tach_edge = t_s2_q & ~t_s3_q;

    // ------------------------------------------------------------
    // Channels: PWM core, guard time, edge skip and refresh timer
    // ------------------------------------------------------------
    for (genvar c = 0; c < 3; c++)
    begin : g_ch
        fpo_pkg::fpo_opt_t opt;
        logic pwm_prev_q, pwm_prev_d;
        logic pwm_start;
        logic [7:0] guard_q, guard_d;
        logic [1:0] skip_q, skip_d;
        logic [13:0] ms_q, ms_d;
        logic refresh_q, refresh_d;
        logic [7:0] guard_len;
        logic [13:0] period_ms;

        assign opt = fpo_pkg::fpo_opt_t'(opt_q[c]);

        fpo_chan #(.PERIOD_W(PERIOD_W)) u_chan (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_snap_off_enable(opt.snap_off_enable),
            .i_period(i_pwm_frequency_config[c*PERIOD_W +: PERIOD_W]),
            .i_duty(i_duty[c*8 +: 8]),
            .i_spinup(i_spinup[c]),
            .i_ramp_tick(i_ramp_tick[c]),
            .o_pwm(o_pwm[c])
        );

        always_comb
        begin
            case ({opt.guard_time_select_hi, opt.guard_time_select_lo})
                2'b00: guard_len = fpo_pkg::GUARD_CODE0;
                2'b01: guard_len = fpo_pkg::GUARD_CODE1;
                2'b10: guard_len = fpo_pkg::GUARD_CODE2;
                default: guard_len = fpo_pkg::GUARD_CODE3;
            endcase
            case ({opt.refresh_rate_select_hi, opt.refresh_rate_select_lo})
                2'b00: period_ms = 14'(fpo_pkg::REFRESH_1S_MS);
                2'b01: period_ms = 14'(fpo_pkg::REFRESH_HALF_MS);
                default: period_ms = 14'(fpo_pkg::REFRESH_FAST_MS);
            endcase
            pwm_prev_d = o_pwm[c];
            pwm_start = o_pwm[c] && !pwm_prev_q;
            guard_d = guard_q;
            skip_d = skip_q;
            if (pwm_start)
            begin
                guard_d = guard_len;
                skip_d = i_skip_initial_edges[c] ? 2'(fpo_pkg::SKIP_EDGES) : 2'd0;
            end
            else if (guard_q != 8'h00 && guard_tick)
                guard_d = guard_q - 8'h01;
            else if (guard_q == 8'h00 && skip_q != 2'd0 && o_tach_edge[c])
                skip_d = skip_q - 2'd1;
            refresh_d = 1'b0;
            ms_d = ms_q;
            if (!i_enhanced[c])
            begin
                ms_d = '0;
                refresh_d = i_reading_valid[c];
            end
            else if (opt.opportunistic_refresh_enable && i_reading_valid[c])
            begin
                ms_d = '0;
                refresh_d = 1'b1;
            end
            else if (ms_tick)
            begin
                if (ms_q + 14'd1 >= period_ms)
                begin
                    ms_d = '0;
                    refresh_d = 1'b1;
                end
                else
                    ms_d = ms_q + 14'd1;
            end
        end

        always_ff @(posedge i_clk or posedge i_rst)
        begin
            if (i_rst)
            begin
                pwm_prev_q <= 1'b0;
                guard_q <= 8'h00;
                skip_q <= 2'd0;
                ms_q <= '0;
                refresh_q <= 1'b0;
            end
            else
            begin
                pwm_prev_q <= pwm_prev_d;
                guard_q <= guard_d;
                skip_q <= skip_d;
                ms_q <= ms_d;
                refresh_q <= refresh_d;
            end
        end
        assign o_refresh[c] = refresh_q;
        // Turn-on cycle blocks too, since the guard load lands one edge later
        assign o_edge_count_en[c] = !i_enhanced[c] || (guard_q == 8'h00 && skip_q == 2'd0 && !pwm_start);
    end
endmodule // fpo_top
`default_nettype wire

// ---- common/fpo_pkg.sv ----
package fpo_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH = 3;
    localparam logic [7:0] PWM1_SAMPLING_OPTIONS_ADDR = 8'h94;
    localparam logic [7:0] PWM2_SAMPLING_OPTIONS_ADDR = 8'h95;
    localparam logic [7:0] PWM3_SAMPLING_OPTIONS_ADDR = 8'h96;
    localparam logic [7:0] OPT_RESET = 8'h0c;
    localparam logic [7:0] OPT_WRITE_MASK = 8'h3f;
    // Field positions
    localparam int unsigned RATE_LSB = 0;
    localparam int unsigned SNAP_BIT = 2;
    localparam int unsigned GUARD_LSB = 3;
    localparam int unsigned OPP_BIT = 5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned GUARD_CLK_HZ = 90_000;
    localparam int unsigned GUARD_DIV = CLK_HZ / GUARD_CLK_HZ;
    localparam int unsigned REFRESH_1S_MS = 1000;
    localparam int unsigned REFRESH_HALF_MS = 500;
    localparam int unsigned REFRESH_FAST_MS = 300;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    localparam logic [7:0] GUARD_CODE0 = 8'h3f;
    localparam logic [7:0] GUARD_CODE1 = 8'h20;
    localparam logic [7:0] GUARD_CODE2 = 8'h10;
    localparam logic [7:0] GUARD_CODE3 = 8'h08;
    localparam int unsigned SKIP_EDGES = 3;
    localparam int unsigned DUTY_STEPS = 256;

    typedef struct packed {
        logic [1:0] reserved;
        logic opportunistic_refresh_enable;
        logic guard_time_select_hi;
        logic guard_time_select_lo;
        logic snap_off_enable;
        logic refresh_rate_select_hi;
        logic refresh_rate_select_lo;
    } fpo_opt_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fpo_reg_req_t;
endpackage

// ---- hdl/fpo_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpo_chan #(
    parameter int unsigned PERIOD_W = 24
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_snap_off_enable,
    input wire logic [PERIOD_W-1:0] i_period,
    input wire logic [7:0] i_duty,
    input wire logic i_spinup,
    input wire logic i_ramp_tick,
    // Outputs
    output logic o_pwm
);
    // ------------------------------------------------------------
    // Duty and PWM counter
    // ------------------------------------------------------------
    logic [7:0] duty_q, duty_d;
    logic [PERIOD_W-1:0] cnt_q, cnt_d;
    logic pwm_q, pwm_d;
    logic [PERIOD_W+7:0] high_scaled;

    always_comb
    begin
        duty_d = duty_q;
        if (i_duty == 8'h00 && i_snap_off_enable)
            duty_d = 8'h00;
        else if (i_duty < duty_q && !i_snap_off_enable)
        begin
            if (i_ramp_tick)
                duty_d = duty_q - 8'h01;
        end
        else
            duty_d = i_duty;
        cnt_d = (cnt_q >= i_period - 1'b1) ? '0 : cnt_q + 1'b1;
        // Compare in the scaled domain so no division is needed per cycle
        high_scaled = {8'h00, cnt_q} * (PERIOD_W+8)'(fpo_pkg::DUTY_STEPS);
        pwm_d = i_spinup || (high_scaled < (PERIOD_W+8)'(i_period) * (PERIOD_W+8)'(duty_q));
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            duty_q <= 8'h00;
            cnt_q <= '0;
            pwm_q <= 1'b0;
        end
        else
        begin
            duty_q <= duty_d;
            cnt_q <= cnt_d;
            pwm_q <= pwm_d;
        end
    end
    assign o_pwm = pwm_q;

endmodule // fpo_chan
`default_nettype wire

// ---- sim/fpo_fan_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Fan with open-drain tach, pulled up while stopped
// ----
module fpo_fan_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Drive and tach
    input wire logic i_pwm,
    output logic o_tach
);
    int idle_q;
    int ph_q;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            idle_q <= 2000;
            ph_q <= 0;
            o_tach <= 1'b1;
        end
        else
        begin
            idle_q <= i_pwm ? 0 : (idle_q < 2000 ? idle_q + 1 : idle_q);
            ph_q <= (ph_q == 36) ? 0 : ph_q + 1;
            // Rotor coasts a while after drive stops, then the pull-up wins
            o_tach <= (idle_q >= 2000) ? 1'b1 : (ph_q == 36 ? ~o_tach : o_tach);
        end
    end
endmodule // fpo_fan_model
`default_nettype wire

// ---- sim/fpo_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpo_checker #(
    parameter int unsigned PERIOD_W = 24
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Watched ports
    input wire fpo_pkg::fpo_reg_req_t i_req,
    input wire logic [2:0] i_enhanced,
    input wire logic [2:0] i_spinup,
    input wire logic [2:0] i_tach_pin,
    input wire logic [2:0] i_reading_valid,
    input wire logic [7:0] o_rdata,
    input wire logic [2:0] o_pwm,
    input wire logic [2:0] o_refresh,
    input wire logic [2:0] o_edge_count_en,
    input wire logic [2:0] o_tach_edge
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_blocked;
        (!o_edge_count_en[0])[*6];
    endsequence
    property p_unmap; i_req.rd && (i_req.addr < 8'h94 || i_req.addr > 8'h96) |=> o_rdata == 8'h00; endproperty
    property p_rsv; i_req.rd |=> o_rdata[7:6] == 2'b00; endproperty
    property p_stand; !i_req.rd |=> $stable(o_rdata); endproperty
    property p_spin; i_spinup[0] |=> o_pwm[0]; endproperty
    property p_std; !i_enhanced[2] && i_reading_valid[2] |=> o_refresh[2]; endproperty
    property p_edge; $rose(i_tach_pin[1]) |-> ##[1:4] o_tach_edge[1]; endproperty
    property p_pulse; o_tach_edge[1] |=> !o_tach_edge[1]; endproperty
    property p_guard; $rose(o_pwm[0]) && i_enhanced[0] |-> ##2 s_blocked; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_rsv: assert property (p_rsv) else $error("upper bits not zero");
    a_stand: assert property (p_stand) else $error("read data moved");
    a_spin: assert property (p_spin) else $error("spin-up not full on");
    a_std: assert property (p_std) else $error("standard refresh missing");
    a_edge: assert property (p_edge) else $error("tach edge lost");
    a_pulse: assert property (p_pulse) else $error("tach edge too long");
    a_guard: assert property (p_guard) else $error("counting inside guard");
endmodule // fpo_checker
bind fpo_top fpo_checker #(.PERIOD_W(PERIOD_W)) u_fpo_checker (.i_clk(i_clk), .i_rst(i_rst),
    .i_req(i_req), .i_enhanced(i_enhanced), .i_spinup(i_spinup), .i_tach_pin(i_tach_pin),
    .i_reading_valid(i_reading_valid), .o_rdata(o_rdata), .o_pwm(o_pwm), .o_refresh(o_refresh),
    .o_edge_count_en(o_edge_count_en), .o_tach_edge(o_tach_edge));
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    fpo_pkg::fpo_reg_req_t req = '0;
    logic lock = 1'b0;
    logic [2:0] enh = 3'h0, skip = 3'h1, spin = 3'h0, rt = 3'h0, rv = 3'h0;
    logic [71:0] per = {24'h00_0100, 24'h00_0100, 24'h00_0200};
    logic [23:0] duty = 24'h00_0000;
    logic [2:0] pwm, refr, cen, tedge;
    wire [2:0] tach;
    logic [7:0] rdata;
    int err_total = 0, n_compared = 0, seed = 14, mdl[3], h, k, a, d;
    int dq[$] = '{0, 1, 255};
    fpo_top u_fpo_top (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_lock(lock), .o_rdata(rdata),
        .i_enhanced(enh), .i_skip_initial_edges(skip), .i_pwm_frequency_config(per), .i_duty(duty),
        .i_spinup(spin), .i_ramp_tick(rt), .i_tach_pin(tach), .i_reading_valid(rv), .o_pwm(pwm),
        .o_refresh(refr), .o_edge_count_en(cen), .o_tach_edge(tedge));
    for (genvar g = 0; g < 3; g++)
    begin : g_fan
        fpo_fan_model u_fpo_fan_model (.i_clk(i_clk), .i_rst(i_rst), .i_pwm(pwm[g]), .o_tach(tach[g]));
    end
    initial
    begin
        forever #10 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Model follows lock, address window and the writable mask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        req.wr = 1'b1;
        req.addr = ad;
        req.wdata = dt;
        if (!lock && ad >= 8'h94 && ad <= 8'h96) mdl[ad - 8'h94] = dt & 8'h3f;
        tick(1);
        req.wr = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        req.rd = 1'b1;
        req.addr = ad;
        tick(1);
        req.rd = 1'b0;
        chk(rdata, e, "rdata");
        tick(1);
    endtask
    task automatic hi(input int ch, input int n, output int c);
        c = 0;
        repeat (n)
        begin
            tick(1);
            c += (pwm[ch] === 1'b1);
        end
    endtask
    initial
    begin
        #(20 * 100000);
        err_total++;
        complete_run();
    end
    initial
    begin
        tick(20);
        i_rst = 1'b0;
        for (a = 0; a < 3; a++)
        begin
            mdl[a] = 8'h0c;
            rd(8'h94 + a, 8'h0c);
        end
        wr(8'h95, 8'hff);
        rd(8'h95, mdl[1]);
        repeat (12)
        begin
            a = $unsigned($random(seed)) % 3;
            d = $random(seed) & 255;
            wr(8'h94 + a, d);
            rd(8'h94 + a, mdl[a]);
        end
        // Channel 0 short guard, channel 1 ramps down, channel 2 opportunistic
        wr(8'h94, 8'h1c);
        wr(8'h95, 8'h08);
        wr(8'h96, 8'h2c);
        lock = 1'b1;
        wr(8'h94, $random(seed));
        rd(8'h94, mdl[0]);
        lock = 1'b0;
        rd(8'h97, 8'h00);
        dq.push_back($unsigned($random(seed)) % 256);
        foreach (dq[i])
        begin
            duty[7:0] = dq[i];
            tick(1100);
            hi(0, 1024, h);
            chk(h, dq[i] * 4, "high time");
        end
        duty[7:0] = 8'h00;
        enh[0] = 1'b1;
        tick(1100);
        spin[0] = 1'b1;
        tick(1);
        chk(cen[0], 0, "guard at turn-on");
        k = 1;
        while (cen[0] !== 1'b1)
        begin
            tick(1);
            k++;
            if (k > 6000)
            begin
                err_total++;
                complete_run();
            end
        end
        // Free-running 90 kHz tick: 8 guard ticks, then 3 skipped fan edges 74 cycles apart
        chk(k >= 7 * fpo_pkg::GUARD_DIV + 2 * 74 && k <= 8 * fpo_pkg::GUARD_DIV + 3 * 74 + 8, 1, "guard wait");
        hi(0, 1024, h);
        chk(h, 1024, "spin-up");
        k = 0;
        repeat (740)
        begin
            tick(1);
            k += (tedge[0] === 1'b1);
        end
        chk(k, 10, "tach edges");
        duty[15:8] = 8'h64;
        tick(600);
        duty[15:8] = 8'h00;
        tick(600);
        hi(1, 512, h);
        chk(h, 200, "no snap");
        repeat (3)
        begin
            rt[1] = 1'b1;
            tick(1);
            rt[1] = 1'b0;
            tick(1);
        end
        tick(600);
        hi(1, 512, h);
        chk(h, 194, "ramp step");
        for (a = 0; a < 2; a++)
        begin
            enh[2] = a;
            tick(2);
            rv[2] = 1'b1;
            tick(1);
            rv[2] = 1'b0;
            chk(refr[2], 1, "refresh");
        end
        wr(8'h96, 8'h0e);
        rv[2] = 1'b1;
        tick(1);
        rv[2] = 1'b0;
        k = 0;
        repeat (4)
        begin
            k += (refr[2] === 1'b1);
            tick(1);
        end
        chk(k, 0, "period refresh");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
